// [hw/bst_cells.sv]
// boundary-scan register: input, output and control cells
// assumes one-cycle capture, shift and update enables from the tap
`timescale 1ns/100ps
module bst_cells
    import bst_pkg::*;
#(
    parameter int LEN = `BST_BSR_LEN
)(
    input  wire logic           clk,
    input  wire logic           sys_rst,
    bst_if.cells                bus,
    input  wire logic [LEN-1:0] pin_in,
    input  wire logic [LEN-1:0] core_val,
    output logic      [LEN-1:0] pin_drive
);

// ----------------------------------------
// state
// ----------------------------------------
bst_cell_state_type cell_reg;
bst_cell_state_type cell_next;
logic [LEN-1:0]     in_mask;
logic [LEN-1:0]     ctrl_mask;
logic [LEN-1:0]     sample_val;
logic               force_upd;

assign in_mask   = LEN'(`BST_IN_MASK);
assign ctrl_mask = LEN'(`BST_CTRL_MASK);
// input cells see the pin, others the functional value
assign sample_val = (cell_reg.in_s2 & in_mask) | (core_val & ~in_mask);
assign force_upd  = bus.extest | bus.clamp;
assign bus.so     = cell_reg.cap[0];
assign pin_drive  = cell_reg.drive;

// ----------------------------------------
// next state
// ----------------------------------------
always_comb
begin
    cell_next       = cell_reg;
    cell_next.in_s1 = pin_in;
    cell_next.in_s2 = cell_reg.in_s1;
    if (bus.shift)
    begin
        cell_next.cap = {bus.si, cell_reg.cap[LEN-1:1]};
    end
    else if (bus.capture)
    begin
        cell_next.cap = sample_val;
    end
    // input cells keep no update stage
    if (bus.update)
    begin
        cell_next.upd = cell_reg.cap & ~in_mask;
    end
    // scanned values reach pins only in extest or clamp
    cell_next.drive = force_upd ? cell_reg.upd : core_val;
    if (bus.highz)
    begin
        cell_next.drive = cell_next.drive | ctrl_mask;
    end
end

always_ff @(posedge clk)
begin
    if (sys_rst)
    begin
        cell_reg <= '0;
    end
    else
    begin
        cell_reg <= cell_next;
    end
end

endmodule : bst_cells

// [hw/bst_consts.svh]
// constants of the boundary-scan test access port
// assumes inclusion by bst_pkg only
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

// ----------------------------------------
// instruction register
// ----------------------------------------
`define BST_IR_W        3
`define BST_IR_CAPTURE  3'h5
`define BST_OP_EXTEST   3'h0
`define BST_OP_SAMPLE   3'h1
`define BST_OP_IDCODE   3'h2
`define BST_OP_TESTMODE 3'h3
`define BST_OP_HIGHZ    3'h4
`define BST_OP_CLAMP    3'h6

// ----------------------------------------
// data registers
// ----------------------------------------
`define BST_BSR_LEN     38
`define BST_TM_W        8
`define BST_ID_W        32
`define BST_TM_RESET    8'h00
// cells that only capture a pin
`define BST_IN_MASK     38'h3E_A000_8100
// cells that steer a group's output enable, high disables
`define BST_CTRL_MASK   38'h00_0009_0440

`endif

// [hw/bst_if.sv]
// link between the tap controller and the boundary cells
// assumes both ends on the same clock
`timescale 1ns/100ps
interface bst_if;
    logic capture;
    logic shift;
    logic update;
    logic extest;
    logic clamp;
    logic highz;
    logic si;
    logic so;
    modport tap   (output capture, shift, update, extest, clamp, highz, si, input so);
    modport cells (input capture, shift, update, extest, clamp, highz, si, output so);
endinterface : bst_if

// [hw/bst_pkg.sv]
// types of the boundary-scan test access port
// assumes bst_consts.svh on the include path
package bst_pkg;
`include "bst_consts.svh"

// ----------------------------------------
// controller states, gray along the usual path
// ----------------------------------------
typedef enum logic [3:0] {
    BST_TLR   = 4'h0,
    BST_RTI   = 4'h1,
    BST_SDR   = 4'h3,
    BST_CDR   = 4'h2,
    BST_SHDR  = 4'h6,
    BST_E1DR  = 4'h7,
    BST_PDR   = 4'h5,
    BST_E2DR  = 4'h4,
    BST_UDR   = 4'hC,
    BST_SIR   = 4'hD,
    BST_CIR   = 4'hF,
    BST_SHIR  = 4'hE,
    BST_E1IR  = 4'hA,
    BST_PIR   = 4'hB,
    BST_E2IR  = 4'h9,
    BST_UIR   = 4'h8
} bst_state_type;

typedef struct packed {
    logic                  tck_s1;
    logic                  tck_s2;
    logic                  tck_s3;
    logic                  tms_s1;
    logic                  tms_s2;
    logic                  tdi_s1;
    logic                  tdi_s2;
    bst_state_type         state;
    logic [`BST_IR_W-1:0]  ir;
    logic [`BST_IR_W-1:0]  ir_sh;
    logic                  byp;
    logic [`BST_ID_W-1:0]  id_sh;
    logic [`BST_TM_W-1:0]  tm_sh;
    logic [`BST_TM_W-1:0]  tm_word;
    logic                  tdo;
    logic                  tdo_oe;
    logic                  pin;
    logic                  pin_oe;
} bst_tap_state_type;

typedef struct packed {
    logic [`BST_BSR_LEN-1:0] in_s1;
    logic [`BST_BSR_LEN-1:0] in_s2;
    logic [`BST_BSR_LEN-1:0] cap;
    logic [`BST_BSR_LEN-1:0] upd;
    logic [`BST_BSR_LEN-1:0] drive;
} bst_cell_state_type;

endpackage : bst_pkg

// [hw/bst_tap.sv]
// boundary-scan test access port with shared test-data-out pin
// assumes tck, tms, tdi arrive asynchronously; tck far below clk
//
// What this block does
// - four-wire port, no separate test reset
// - power-on reset enters test-logic-reset
// - no internal test, no self-test
// - in test-logic-reset pin carries alpha key
// - leaving reset, pin becomes standard test output
// - tms steers states; capture, shift, update sequenced
// - instruction selects data register; ir branch uses ir
// - seven instructions supported
// - highz and clamp per 1992 supplement
// - input cells capture and shift only
// - output cells update from capture stage
// - scanned output drives pin only in extest or clamp
// - four control cells gate group enables
// - pixel clock pin: input plus tristate output
// - single-bit bypass path
// - 32-bit identification register via idcode
// - 8-bit test-mode register, shift and update
// - three-bit ir, captures 101
// - fixed opcodes; unassigned codes select bypass
// - idcode selected after reset
// - 38 boundary cells tdi to tdo
`timescale 1ns/100ps
module bst_tap
    import bst_pkg::*;
#(
    parameter logic [3:0]  ID_VERSION = 4'h1,     // arbitrary
    parameter logic [15:0] ID_PART    = 16'h1234, // arbitrary
    parameter logic [10:0] ID_MAKER   = 11'h055,  // arbitrary
    parameter int          BSR_LEN    = `BST_BSR_LEN
)(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               tck_pin,
    input  wire logic               tms_pin,
    input  wire logic               tdi_pin,
    output logic                    tdo_alpha_out,
    output logic                    tdo_alpha_oe,
    input  wire logic               alpha_key,
    input  wire logic [BSR_LEN-1:0] bnd_pin_in,
    input  wire logic [BSR_LEN-1:0] bnd_core,
    output logic      [BSR_LEN-1:0] bnd_drive,
    output logic [`BST_TM_W-1:0]    test_mode_word,
    output logic                    tap_in_reset
);

// ----------------------------------------
// state and decode
// ----------------------------------------
bst_tap_state_type    tap_reg;
bst_tap_state_type    tap_next;
logic                 tck_rise;
logic                 tck_fall;
logic                 sel_bsr;
logic                 sel_id;
logic                 sel_tm;
logic                 sel_byp;
logic                 dr_lsb;
logic                 st_tlr;
logic                 st_cdr;
logic                 st_shdr;
logic                 st_udr;
logic                 st_shir;
logic                 st_uir;
logic [`BST_ID_W-1:0] id_value;

bst_if cell_bus ();

// tck is sampled, not used as a clock; edges found after sync
assign tck_rise = tap_reg.tck_s2 & ~tap_reg.tck_s3;
assign tck_fall = ~tap_reg.tck_s2 & tap_reg.tck_s3;

// no intest or self-test opcode exists
assign sel_bsr = (tap_reg.ir == `BST_OP_EXTEST) || (tap_reg.ir == `BST_OP_SAMPLE);
assign sel_id  = (tap_reg.ir == `BST_OP_IDCODE);
assign sel_tm  = (tap_reg.ir == `BST_OP_TESTMODE);
// highz, clamp and the unassigned codes fall here
assign sel_byp = ~(sel_bsr | sel_id | sel_tm);

assign id_value = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

// ----------------------------------------
// state decode
// ----------------------------------------
// one compare per state, shared by cell enables and the output path
assign st_tlr  = (tap_reg.state == BST_TLR);
assign st_cdr  = (tap_reg.state == BST_CDR);
assign st_shdr = (tap_reg.state == BST_SHDR);
assign st_udr  = (tap_reg.state == BST_UDR);
assign st_shir = (tap_reg.state == BST_SHIR);
assign st_uir  = (tap_reg.state == BST_UIR);

always_comb
begin
    if (sel_bsr)
    begin
        dr_lsb = cell_bus.so;
    end
    else if (sel_id)
    begin
        dr_lsb = tap_reg.id_sh[0];
    end
    else if (sel_tm)
    begin
        dr_lsb = tap_reg.tm_sh[0];
    end
    else
    begin
        dr_lsb = tap_reg.byp;
    end
end

// ----------------------------------------
// controller transitions
// ----------------------------------------
function automatic bst_state_type bst_step(input bst_state_type s, input logic tms);
    bst_state_type n;
    n = s;
    case (s)
        BST_TLR:  n = tms ? BST_TLR  : BST_RTI;
        BST_RTI:  n = tms ? BST_SDR  : BST_RTI;
        BST_SDR:  n = tms ? BST_SIR  : BST_CDR;
        BST_CDR:  n = tms ? BST_E1DR : BST_SHDR;
        BST_SHDR: n = tms ? BST_E1DR : BST_SHDR;
        BST_E1DR: n = tms ? BST_UDR  : BST_PDR;
        BST_PDR:  n = tms ? BST_E2DR : BST_PDR;
        BST_E2DR: n = tms ? BST_UDR  : BST_SHDR;
        BST_UDR:  n = tms ? BST_SDR  : BST_RTI;
        BST_SIR:  n = tms ? BST_TLR  : BST_CIR;
        BST_CIR:  n = tms ? BST_E1IR : BST_SHIR;
        BST_SHIR: n = tms ? BST_E1IR : BST_SHIR;
        BST_E1IR: n = tms ? BST_UIR  : BST_PIR;
        BST_PIR:  n = tms ? BST_E2IR : BST_PIR;
        BST_E2IR: n = tms ? BST_UIR  : BST_SHIR;
        BST_UIR:  n = tms ? BST_SDR  : BST_RTI;
        default:  n = BST_TLR;
    endcase
    return n;
endfunction : bst_step

// ----------------------------------------
// boundary cell enables
// ----------------------------------------
assign cell_bus.capture = tck_rise & st_cdr & sel_bsr;
assign cell_bus.shift   = tck_rise & st_shdr & sel_bsr;
assign cell_bus.update  = tck_fall & st_udr & sel_bsr;
assign cell_bus.extest  = (tap_reg.ir == `BST_OP_EXTEST);
assign cell_bus.clamp   = (tap_reg.ir == `BST_OP_CLAMP);
assign cell_bus.highz   = (tap_reg.ir == `BST_OP_HIGHZ);
assign cell_bus.si      = tap_reg.tdi_s2;

// pixel clock pin sits in the chain as input, output and control cell
bst_cells #(
    .LEN       (BSR_LEN)
) u_cells (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .bus       (cell_bus.cells),
    .pin_in    (bnd_pin_in),
    .core_val  (bnd_core),
    .pin_drive (bnd_drive)
);

// ----------------------------------------
// next state
// ----------------------------------------
always_comb
begin
    tap_next        = tap_reg;
    tap_next.tck_s1 = tck_pin;
    tap_next.tck_s2 = tap_reg.tck_s1;
    tap_next.tck_s3 = tap_reg.tck_s2;
    tap_next.tms_s1 = tms_pin;
    tap_next.tms_s2 = tap_reg.tms_s1;
    tap_next.tdi_s1 = tdi_pin;
    tap_next.tdi_s2 = tap_reg.tdi_s1;

    if (tck_rise)
    begin
        tap_next.state = bst_step(tap_reg.state, tap_reg.tms_s2);
        case (tap_reg.state)
            BST_CIR:
            begin
                tap_next.ir_sh = `BST_IR_CAPTURE;
            end
            BST_SHIR:
            begin
                tap_next.ir_sh = {tap_reg.tdi_s2, tap_reg.ir_sh[`BST_IR_W-1:1]};
            end
            BST_CDR:
            begin
                // test-mode register has no capture: last word comes back
                if (sel_id)
                begin
                    tap_next.id_sh = id_value;
                end
                else if (sel_byp)
                begin
                    tap_next.byp = 1'b0;
                end
            end
            BST_SHDR:
            begin
                if (sel_id)
                begin
                    tap_next.id_sh = {tap_reg.tdi_s2, tap_reg.id_sh[`BST_ID_W-1:1]};
                end
                else if (sel_tm)
                begin
                    tap_next.tm_sh = {tap_reg.tdi_s2, tap_reg.tm_sh[`BST_TM_W-1:1]};
                end
                else if (sel_byp)
                begin
                    tap_next.byp = tap_reg.tdi_s2;
                end
            end
            default:
            begin
                tap_next.byp = tap_reg.byp;
            end
        endcase
    end

    if (tck_fall)
    begin
        // output changes on the falling edge, as the far end expects
        if (st_shir)
        begin
            tap_next.tdo    = tap_reg.ir_sh[0];
            tap_next.tdo_oe = 1'b1;
        end
        else if (st_shdr)
        begin
            tap_next.tdo    = dr_lsb;
            tap_next.tdo_oe = 1'b1;
        end
        else
        begin
            tap_next.tdo_oe = 1'b0;
        end
        if (st_uir)
        begin
            tap_next.ir = tap_reg.ir_sh;
        end
        if (st_udr && sel_tm)
        begin
            tap_next.tm_word = tap_reg.tm_sh;
        end
    end

    if (st_tlr)
    begin
        tap_next.ir     = `BST_OP_IDCODE;
        tap_next.tdo_oe = 1'b0;
    end

    // shared pin: alpha key while in reset, scan output otherwise
    if (tap_next.state == BST_TLR)
    begin
        tap_next.pin    = alpha_key;
        tap_next.pin_oe = 1'b1;
    end
    else
    begin
        tap_next.pin    = tap_next.tdo;
        tap_next.pin_oe = tap_next.tdo_oe;
    end
end

// ----------------------------------------
// registers
// ----------------------------------------
// sys_rst doubles as the power-on reset; no test reset pin exists
always_ff @(posedge clk)
begin
    if (sys_rst)
    begin
        tap_reg         <= '0;
        tap_reg.state   <= BST_TLR;
        tap_reg.ir      <= `BST_OP_IDCODE;
        tap_reg.tm_word <= `BST_TM_RESET;
        tap_reg.pin_oe  <= 1'b1;
    end
    else
    begin
        tap_reg <= tap_next;
    end
end

// ----------------------------------------
// outputs
// ----------------------------------------
assign tdo_alpha_out  = tap_reg.pin;
assign tdo_alpha_oe   = tap_reg.pin_oe;
assign test_mode_word = tap_reg.tm_word;
assign tap_in_reset   = st_tlr;

endmodule : bst_tap

// [verif/bst_tap_asserts.sv]
// checker for the boundary-scan port, sees only bst_tap ports
// assumes bst_pkg compiled first; bound into every bst_tap
`timescale 1ns/100ps
module bst_tap_asserts
    import bst_pkg::*;
#(
    parameter int BSR_LEN = `BST_BSR_LEN
)(
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               tck_pin,
    input wire logic               tms_pin,
    input wire logic               tdi_pin,
    input wire logic               tdo_alpha_out,
    input wire logic               tdo_alpha_oe,
    input wire logic               alpha_key,
    input wire logic [BSR_LEN-1:0] bnd_pin_in,
    input wire logic [BSR_LEN-1:0] bnd_core,
    input wire logic [BSR_LEN-1:0] bnd_drive,
    input wire logic [`BST_TM_W-1:0] test_mode_word,
    input wire logic               tap_in_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // reset and shared pin
    // ----------------------------------------
    a_reset_entry: assert property (disable iff (1'b0) sys_rst |=> tap_in_reset)
        else $error("tap not in reset after sys_rst");
    a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> test_mode_word == '0 && bnd_drive == '0)
        else $error("outputs not cleared by sys_rst");
    // pin follows the state being entered, so judge it by the present state
    a_alpha_share: assert property (!$past(sys_rst) && tap_in_reset |->
        tdo_alpha_oe && tdo_alpha_out == $past(alpha_key))
        else $error("shared pin not carrying alpha key");
    // sync depth makes the output move while tck is still low
    a_out_on_fall: assert property (!tap_in_reset && !$past(tap_in_reset) && !$past(tap_in_reset, 2)
        && !$past(tap_in_reset, 3) && ($changed(tdo_alpha_out) || $changed(tdo_alpha_oe)) |-> !$past(tck_pin, 2))
        else $error("test output moved outside tck low phase");
    // ----------------------------------------
    // state walk and registers
    // ----------------------------------------
    a_leave_tms_low: assert property ($fell(tap_in_reset) |-> !$past(tms_pin, 3))
        else $error("left reset state with tms high");
    a_enter_tms_high: assert property ($rose(tap_in_reset) |-> $past(tms_pin, 3))
        else $error("entered reset state with tms low");
    a_drive_normal: assert property (!$past(sys_rst) && $past(tap_in_reset) && $past(tap_in_reset, 2)
        |-> bnd_drive == $past(bnd_core))
        else $error("pins not on functional path in reset state");
    a_word_hold: assert property (tap_in_reset && $past(tap_in_reset) |-> $stable(test_mode_word))
        else $error("test word changed in reset state");
    c_leave: cover property ($fell(tap_in_reset));
    c_word: cover property ($changed(test_mode_word));
    c_forced: cover property (bnd_drive != bnd_core);
endmodule : bst_tap_asserts

bind bst_tap bst_tap_asserts #(.BSR_LEN(BSR_LEN)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .tck_pin(tck_pin), .tms_pin(tms_pin), .tdi_pin(tdi_pin),
    .tdo_alpha_out(tdo_alpha_out), .tdo_alpha_oe(tdo_alpha_oe), .alpha_key(alpha_key),
    .bnd_pin_in(bnd_pin_in), .bnd_core(bnd_core), .bnd_drive(bnd_drive),
    .test_mode_word(test_mode_word), .tap_in_reset(tap_in_reset));

// [verif/bst_tester.sv]
// model of the external scan tester driving the four-wire link
// assumes 48 ns tck; tck stands low between frames
`timescale 1ns/100ps
module bst_tester (
    output logic     tck,
    output logic     tms,
    output logic     tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // tms and tdi move only at tck fall, held across the rise
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #24 tck = 1'b1;
        #23 q = tdo_oe ? tdo : 1'bx;
        #1 tck = 1'b0;
    endtask : tick
    // data line toggles when unused, never a stale value
    task automatic go(input logic m);
        logic q;
        tick(m, ~tdi, q);
    endtask : go
    task automatic reset_tap;
        repeat (5) go(1'b1);
        go(1'b0);
    endtask : reset_tap
    // from run-test-idle, lsb first, back to run-test-idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        dout = '0;
        go(1'b1);
        if (ir)
            go(1'b1);
        go(1'b0);
        go(1'b0);
        for (int i = 0; i < n; i++)
            tick(i == n - 1, din[i], dout[i]);
        go(1'b1);
        go(1'b0);
    endtask : scan
endmodule : bst_tester

// [verif/tb_top.sv]
// self-checking bench for bst_tap with the tester model
// assumes design, package and checker compiled before it
`timescale 1ns/100ps
module tb_top;
    import bst_pkg::*;
    localparam logic [3:0]  ID_V = 4'h1;     // arbitrary
    localparam logic [15:0] ID_P = 16'h1234; // arbitrary
    localparam logic [10:0] ID_M = 11'h055;  // arbitrary
    localparam logic [37:0] IN_M = `BST_IN_MASK;
    localparam logic [37:0] CT_M = `BST_CTRL_MASK;
    localparam logic [37:0] OUT_M = ~IN_M;
    localparam logic [37:0] PAT = 38'h29_6A5A_C3A5;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        alpha_key = 1'b0;
    logic [37:0] pin_in = 38'h3C_3C3C_3C3C;
    logic [37:0] core = 38'h15_5555_5555;
    logic        tck, tms, tdi, tdo, oe, in_rst;
    logic [37:0] drive;
    logic [7:0]  tmw;
    logic [63:0] d;
    int          n_fail = 0;
    int          n_checks = 0;
    always #2.5 clk = ~clk;
    bst_tap #(.ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MAKER(ID_M)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi),
        .tdo_alpha_out(tdo), .tdo_alpha_oe(oe), .alpha_key(alpha_key), .bnd_pin_in(pin_in),
        .bnd_core(core), .bnd_drive(drive), .test_mode_word(tmw), .tap_in_reset(in_rst));
    bst_tester u_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(oe));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ir_load(input logic [2:0] code);
        logic [63:0] q;
        u_tester.scan(1'b1, 3, 64'(code), q);
        chk(q[2:0], 3'h5);
    endtask : ir_load
    task automatic alpha_chk;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk) #1 alpha_key = ~alpha_key;
            repeat (3) @(posedge clk);
            chk({oe, tdo}, {1'b1, alpha_key});
        end
    endtask : alpha_chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_on;
        chk(in_rst, 1'b1);
        chk(tmw, 8'h00);
        alpha_chk();
    endtask : t_power_on
    task automatic t_idcode;
        u_tester.reset_tap();
        chk({in_rst, oe}, 2'b00);
        u_tester.scan(1'b0, 32, '0, d);
        chk(d[31:0], {ID_V, ID_P, ID_M, 1'b1});
    endtask : t_idcode
    // unassigned codes, highz and clamp all give the one-bit path
    task automatic t_bypass;
        logic [2:0] codes [4] = '{3'h5, 3'h7, 3'h4, 3'h6};
        foreach (codes[i])
        begin
            ir_load(codes[i]);
            u_tester.scan(1'b0, 8, 64'h96, d);
            chk(d[7:0], 8'h2C);
        end
    endtask : t_bypass
    task automatic t_testmode;
        ir_load(3'h3);
        u_tester.scan(1'b0, 8, 64'hA5, d);
        chk(tmw, 8'hA5);
        u_tester.scan(1'b0, 8, 64'h3C, d);
        chk(d[7:0], 8'hA5);
        chk(tmw, 8'h3C);
        // park the test word at its reset value before moving on
        u_tester.scan(1'b0, 8, 64'h00, d);
        chk(d[7:0], 8'h3C);
        chk(tmw, 8'h00);
    endtask : t_testmode
    task automatic t_boundary;
        ir_load(3'h1);
        chk(drive & OUT_M, core & OUT_M);
        u_tester.scan(1'b0, 38, 64'(PAT), d);
        chk(d[37:0] & IN_M, pin_in & IN_M);
        chk(drive & OUT_M, core & OUT_M);
        ir_load(3'h0);
        chk(drive & OUT_M, PAT & OUT_M);
        @(posedge clk) #1 pin_in = ~pin_in;
        u_tester.scan(1'b0, 38, 64'(~PAT), d);
        chk(d[37:0] & IN_M, pin_in & IN_M);
        chk(drive & OUT_M, ~PAT & OUT_M);
    endtask : t_boundary
    task automatic t_clamp_highz;
        ir_load(3'h6);
        chk(drive & OUT_M, ~PAT & OUT_M);
        ir_load(3'h4);
        chk(drive & CT_M, CT_M);
        chk(drive & OUT_M & ~CT_M, core & OUT_M & ~CT_M);
    endtask : t_clamp_highz
    task automatic t_back_reset;
        ir_load(3'h0);
        repeat (5) u_tester.go(1'b1);
        repeat (4) @(posedge clk);
        chk(in_rst, 1'b1);
        chk(drive & OUT_M, core & OUT_M);
        alpha_chk();
        t_idcode();
    endtask : t_back_reset
    initial
    begin
        #300000;
        n_fail++;
        $display("ERROR %0t: watchdog expired", $time);
        wrap_up();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge clk);
        t_power_on();
        t_idcode();
        t_bypass();
        t_testmode();
        t_boundary();
        t_clamp_highz();
        t_back_reset();
        wrap_up();
    end
endmodule : tb_top
